// *** rtl/iptr_resolver.sv ***
// Interrupt priority resolver, trap detector and reset source logic
//
// Function
// - Three-bit priority field per source nibble
// - Nibble top bit reads as zero
// - Priority 0 lowest, 7 highest
// - Equal priority ties resolved by table position
// - Lower interrupt number wins ties, 0 first
// - Vector number is interrupt number plus eight
// - Numbers 39-40, 43-53 unused; low-voltage is 42
// - Any reset restarts fetch at address zero
// - Six error conditions request a device reset
// - Flushed illegal opcode raises no reset
// - Traps levels 11-14, trap level bit set
// - Level seven blocks interrupts, traps still pass
// - Trap taken after offending instruction completes
// - Divide by zero aborts, raises math trap
// - Enabled bit 31 overflow raises math trap
// - Enabled bit 39 overflow raises math trap
// - Oversized shift amount raises math trap
// - Misaligned or unimplemented reads raise address trap
// - Fetch from vector space raises address trap
// - Split MAC: other space counts unimplemented
// - Invalid trap vector raises address trap
// - Traps nest; a lower hard trap over a higher one resets
// - Request flag sets regardless of enable
// - Interrupt only above current processor level
// - Priority zero source never interrupts
// - Hard trap conflict resets, sets status flag
`timescale 1ns/1ns
`default_nettype none

module iptr_resolver (
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic [53:0] SRC_EVENT_IN,
   output logic             IRQ_REQ_OUT,
   output logic      [5:0]  IRQ_VECTOR_OUT,
   output logic      [3:0]  IRQ_LEVEL_OUT,
   input  wire logic        IRQ_ACK_IN,
   input  wire logic        INSTR_DONE_IN,
   input  wire logic        TRAP_RETURN_IN,
   output logic      [3:0]  CPU_LEVEL_OUT,
   input  wire logic        DIV_ZERO_IN,
   input  wire logic [1:0]  ACC_OVF31_IN,
   input  wire logic        GUARD_USED_IN,
   input  wire logic [1:0]  ACC_OVF39_IN,
   input  wire logic        SAT_ANY_IN,
   input  wire logic        SHIFT_BIG_IN,
   output logic             DIV_ABORT_OUT,
   input  wire logic        MISALIGN_IN,
   input  wire logic        DATA_UNIMPL_IN,
   input  wire logic        PROG_UNIMPL_IN,
   input  wire logic        FETCH_VALID_IN,
   input  wire logic [23:0] FETCH_ADDR_IN,
   input  wire logic        MAC_SPLIT_IN,
   input  wire logic        X_IN_YSPACE_IN,
   input  wire logic        Y_IN_XSPACE_IN,
   input  wire logic        TRAP_VEC_BAD_IN,
   input  wire logic        STACK_ERR_IN,
   input  wire logic        OSC_FAIL_IN,
   input  wire logic        WDT_TIMEOUT_IN,
   input  wire logic        UNINIT_W_IN,
   input  wire logic        ILLEGAL_OP_IN,
   input  wire logic        OP_FLUSHED_IN,
   input  wire logic        BROWNOUT_IN,
   input  wire logic        TRAP_LOCKOUT_IN,
   input  wire logic        SOFT_RESET_IN,
   output logic             SYS_RESET_OUT,
   output logic             FETCH_RESTART_OUT,
   output logic      [23:0] RESET_PC_OUT
);

   localparam int N = iptr_pkg::NUM_SRC;

   logic [2:0]          prio_q [N];
   logic [53:0]         flag_q;
   logic [53:0]         flag_d;
   logic [53:0]         en_q;
   logic [2:0]          ipl_q;
   logic                trap_bit_q;
   logic [3:0]          trap_lvl_q;
   logic [2:0]          tctl_q;
   logic [3:0]          tpend_q;
   logic [3:0]          tset;
   logic [3:0]          tack;
   logic [7:0]          cause_q;
   iptr_pkg::iptr_req_e state_q;
   logic [5:0]          vec_q;
   logic [3:0]          lvl_q;
   logic [31:0]         prdata_q;
   logic [31:0]         rd;
   logic                slverr_q;
   logic                sysrst_q;
   logic                restart_q;
   logic                divab_q;

   logic [5:0]          widx;
   logic                map_ok;
   logic                wr_en;
   logic                setup;
   logic [3:0]          cpu_lvl;
   logic                irq_hit;
   logic [2:0]          irq_lvl;
   logic [5:0]          irq_num;
   logic                tr_hit;
   logic [3:0]          tr_lvl;
   logic                trap_go;
   logic                ack_now;
   logic                math_c;
   logic                addr_c;
   logic                vec_fetch;
   logic                conflict;
   logic [5:0]          rst_src;

   // Word-aligned, inside the populated part of the map
   function automatic logic mapped(input logic [11:0] a);
      logic [5:0] w;
      w = a[7:2];
      mapped = (a[11:8] == 4'h0) && (a[1:0] == 2'h0) &&
               ((w < iptr_pkg::N_PRIO) ||
                ((w >= iptr_pkg::W_FLAG) && (w <= iptr_pkg::W_VEC)));
   endfunction : mapped

   // APB decode, zero wait states
   assign widx       = PADDR_IN[7:2];
   assign map_ok     = mapped(PADDR_IN);
   assign setup      = PSEL_IN & ~PENABLE_IN;
   assign wr_en      = PSEL_IN & PENABLE_IN & PWRITE_IN & map_ok;
   assign PREADY_OUT = 1'b1;
   assign PRDATA_OUT = prdata_q;
   assign PSLVERR_OUT = slverr_q;

   // Priority fields
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         for (int i = 0; i < N; i++) begin
            prio_q[i] <= iptr_pkg::PRIO_RST;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr_en && (widx == 6'(i / 4))) begin
               prio_q[i] <= PWDATA_IN[(i % 4) * 4 +: 3];
            end
         end
      end
   end

   // Request flags: write zero clears, a new event wins
   always_comb begin
      for (int i = 0; i < N; i++) begin
         flag_d[i] = (flag_q[i] &
                      ~(wr_en &&
                        (widx == iptr_pkg::W_FLAG + 6'(i / 16)) &&
                        !PWDATA_IN[i % 16])) |
                     SRC_EVENT_IN[i];
         flag_d[i] = flag_d[i] & iptr_pkg::SRC_IMPL[i];
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   // Request enables
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         en_q <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr_en && (widx == iptr_pkg::W_EN + 6'(i / 16))) begin
               en_q[i] <= PWDATA_IN[i % 16];
            end
         end
      end
   end

   // Trap condition enables
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         tctl_q <= iptr_pkg::TCTL_RST;
      end else if (wr_en && (widx == iptr_pkg::W_TCTL)) begin
         tctl_q <= PWDATA_IN[2:0];
      end
   end

   // Processor level, acceptance overrides a software write
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ipl_q <= iptr_pkg::IPL_RST;
      end else if (ack_now && !lvl_q[3]) begin
         ipl_q <= lvl_q[2:0];
      end else if (wr_en && (widx == iptr_pkg::W_CPU)) begin
         ipl_q <= PWDATA_IN[2:0];
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         trap_bit_q <= 1'b0;
         trap_lvl_q <= 4'h0;
      end else if (ack_now && lvl_q[3]) begin
         trap_bit_q <= 1'b1;
         trap_lvl_q <= lvl_q;
      end else if (TRAP_RETURN_IN) begin
         trap_bit_q <= 1'b0;
         trap_lvl_q <= 4'h0;
      end
   end

   assign cpu_lvl       = {trap_bit_q, ipl_q};
   assign CPU_LEVEL_OUT = cpu_lvl;

   // Trap conditions
   assign math_c = DIV_ZERO_IN |
                   ((|(ACC_OVF31_IN & {tctl_q[iptr_pkg::TC_OVB],
                                      tctl_q[iptr_pkg::TC_OVA]})) &
                    ~GUARD_USED_IN) |
                   (tctl_q[iptr_pkg::TC_COV] & (|ACC_OVF39_IN) &
                    ~SAT_ANY_IN) |
                   SHIFT_BIG_IN;

   assign vec_fetch = FETCH_VALID_IN &&
                      (FETCH_ADDR_IN >= iptr_pkg::VEC_LO) &&
                      (FETCH_ADDR_IN <= iptr_pkg::VEC_HI);

   assign addr_c = MISALIGN_IN | DATA_UNIMPL_IN | PROG_UNIMPL_IN |
                   vec_fetch |
                   (MAC_SPLIT_IN & (X_IN_YSPACE_IN | Y_IN_XSPACE_IN)) |
                   TRAP_VEC_BAD_IN;

   assign tset = {OSC_FAIL_IN, STACK_ERR_IN, addr_c, math_c};

   always_comb begin
      for (int i = 0; i < iptr_pkg::NUM_TRAP; i++) begin
         tack[i] = ack_now && (lvl_q == iptr_pkg::LVL_MATH + 4'(i));
      end
   end

   // Pending traps, a new condition wins over the acceptance
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         tpend_q <= 4'h0;
      end else begin
         tpend_q <= (tpend_q & ~tack) | tset;
      end
   end

   // Lower hard trap against a higher one pending or in service
   always_comb begin
      conflict = 1'b0;
      for (int i = 1; i < iptr_pkg::NUM_TRAP; i++) begin
         if (tset[i] &&
             ((|(tpend_q >> (i + 1))) ||
              (trap_bit_q &&
               (trap_lvl_q > iptr_pkg::LVL_MATH + 4'(i))))) begin
            conflict = 1'b1;
         end
      end
   end

   // Highest pending trap, traps ignore the processor level
   always_comb begin
      tr_hit = 1'b0;
      tr_lvl = iptr_pkg::TRAP_BASE;
      for (int i = 0; i < iptr_pkg::NUM_TRAP; i++) begin
         if (tpend_q[i]) begin
            tr_hit = 1'b1;
            tr_lvl = iptr_pkg::LVL_MATH + 4'(i);
         end
      end
   end

   assign trap_go = tr_hit & INSTR_DONE_IN;

   // Interrupt winner; descending scan lets the lower number win ties
   always_comb begin
      irq_hit = 1'b0;
      irq_lvl = 3'h0;
      irq_num = 6'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (flag_q[i] && en_q[i] && iptr_pkg::SRC_IMPL[i] &&
             (prio_q[i] != 3'h0) &&
             ({1'b0, prio_q[i]} > cpu_lvl) &&
             (!irq_hit || (prio_q[i] >= irq_lvl))) begin
            irq_hit = 1'b1;
            irq_lvl = prio_q[i];
            irq_num = 6'(i);
         end
      end
   end

   // Request handshake toward the core
   assign ack_now = (state_q == iptr_pkg::REQ_HOLD) && IRQ_ACK_IN;

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_q <= iptr_pkg::REQ_IDLE;
      end else begin
         case (state_q)
            iptr_pkg::REQ_IDLE: begin
               if (trap_go || irq_hit) begin
                  state_q <= iptr_pkg::REQ_HOLD;
               end
            end
            iptr_pkg::REQ_HOLD: begin
               if (IRQ_ACK_IN) begin
                  state_q <= iptr_pkg::REQ_IDLE;
               end
            end
            default: begin
               state_q <= iptr_pkg::REQ_IDLE;
            end
         endcase
      end
   end

   // Vector and level latch, frozen while the strobe stands
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         vec_q <= 6'h00;
         lvl_q <= 4'h0;
      end else if (state_q == iptr_pkg::REQ_IDLE) begin
         if (trap_go) begin
            vec_q <= {3'h0, tr_lvl[2:0]};
            lvl_q <= tr_lvl;
         end else if (irq_hit) begin
            vec_q <= irq_num + iptr_pkg::VEC_OFS;
            lvl_q <= {1'b0, irq_lvl};
         end
      end
   end

   assign IRQ_REQ_OUT    = (state_q == iptr_pkg::REQ_HOLD);
   assign IRQ_VECTOR_OUT = vec_q;
   assign IRQ_LEVEL_OUT  = lvl_q;

   // Reset sources
   assign rst_src = {SOFT_RESET_IN, TRAP_LOCKOUT_IN, BROWNOUT_IN,
                     ILLEGAL_OP_IN & ~OP_FLUSHED_IN,
                     UNINIT_W_IN, WDT_TIMEOUT_IN};

   // Cause flags: write zero clears, a new cause wins
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cause_q <= iptr_pkg::CAUSE_RST;
      end else begin
         if (wr_en && (widx == iptr_pkg::W_RST)) begin
            cause_q <= (cause_q & PWDATA_IN[7:0]) |
                       {conflict, 1'b0, rst_src};
         end else begin
            cause_q <= cause_q | {conflict, 1'b0, rst_src};
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         sysrst_q  <= 1'b0;
         restart_q <= 1'b1;
         divab_q   <= 1'b0;
      end else begin
         sysrst_q  <= (|rst_src) | conflict;
         restart_q <= sysrst_q;
         divab_q   <= DIV_ZERO_IN;
      end
   end

   assign SYS_RESET_OUT     = sysrst_q;
   assign FETCH_RESTART_OUT = restart_q;
   assign RESET_PC_OUT      = iptr_pkg::RESET_PC;
   assign DIV_ABORT_OUT     = divab_q;

   // Read mux
   always_comb begin
      logic [63:0] f64;
      logic [63:0] e64;
      int          k;
      f64 = {10'h000, flag_q};
      e64 = {10'h000, en_q};
      k   = 0;
      rd  = 32'h0000_0000;
      if (!map_ok) begin
         rd = 32'h0000_0000;
      end else if (widx < iptr_pkg::N_PRIO) begin
         for (int j = 0; j < 4; j++) begin
            k = int'(widx) * 4 + j;
            if (k < N) begin
               rd[j * 4 +: 3] = prio_q[k];
            end
         end
      end else if (widx < iptr_pkg::W_EN) begin
         rd[15:0] = f64[int'(widx - iptr_pkg::W_FLAG) * 16 +: 16];
      end else if (widx < iptr_pkg::W_CPU) begin
         rd[15:0] = e64[int'(widx - iptr_pkg::W_EN) * 16 +: 16];
      end else begin
         case (widx)
            iptr_pkg::W_CPU: begin
               rd[3:0] = cpu_lvl;
            end
            iptr_pkg::W_TCTL: begin
               rd[2:0] = tctl_q;
               rd[iptr_pkg::TC_PEND +: 4] = tpend_q;
            end
            iptr_pkg::W_RST: begin
               rd[7:0] = cause_q;
            end
            iptr_pkg::W_VEC: begin
               rd[5:0] = vec_q;
               rd[iptr_pkg::VS_LVL +: 4] = lvl_q;
               rd[iptr_pkg::VS_REQ] = IRQ_REQ_OUT;
            end
            default: begin
               rd = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= PWRITE_IN ? 32'h0000_0000 : rd;
         slverr_q <= ~map_ok;
      end
   end

endmodule : iptr_resolver

`default_nettype wire

// *** rtl/iptr_pkg.sv ***
// Constants and types for the interrupt priority and trap resolver
package iptr_pkg;

   // Sources and vectors
   localparam int          NUM_SRC  = 54;
   localparam int          NUM_TRAP = 4;
   localparam logic [53:0] SRC_IMPL = 54'h067F_FFFF_FFFF;
   localparam logic [5:0]  VEC_OFS  = 6'h08;
   localparam logic [5:0]  LVD_NUM  = 6'h2A;
   localparam logic [2:0]  PRIO_RST = 3'h4;

   // Trap levels; pending bit i stands for level LVL_MATH + i
   localparam logic [3:0]  TRAP_BASE = 4'h8;
   localparam logic [3:0]  LVL_MATH  = 4'hB;

   // Program space
   localparam logic [23:0] RESET_PC = 24'h00_0000;
   localparam logic [23:0] VEC_LO   = 24'h00_0004;
   localparam logic [23:0] VEC_HI   = 24'h00_00FE;

   // Register word indices, byte address is four times the index
   localparam logic [5:0]  W_PRIO = 6'h00;
   localparam logic [5:0]  N_PRIO = 6'h0E;
   localparam logic [5:0]  W_FLAG = 6'h10;
   localparam logic [5:0]  W_EN   = 6'h14;
   localparam logic [5:0]  W_CPU  = 6'h18;
   localparam logic [5:0]  W_TCTL = 6'h19;
   localparam logic [5:0]  W_RST  = 6'h1A;
   localparam logic [5:0]  W_VEC  = 6'h1B;

   // Field positions
   localparam int          TC_OVA  = 0;
   localparam int          TC_OVB  = 1;
   localparam int          TC_COV  = 2;
   localparam int          TC_PEND = 8;
   localparam int          RC_CONF = 7;
   localparam int          VS_LVL  = 8;
   localparam int          VS_REQ  = 15;

   // Reset values
   localparam logic [2:0]  TCTL_RST  = 3'h0;
   localparam logic [2:0]  IPL_RST   = 3'h0;
   localparam logic [7:0]  CAUSE_RST = 8'h00;

   typedef enum logic {
      REQ_IDLE = 1'b0,
      REQ_HOLD = 1'b1
   } iptr_req_e;

endpackage : iptr_pkg

// *** testbench/iptr_sva.sv ***
// Port assertions for the interrupt priority and trap resolver
`timescale 1ns/1ns
`default_nettype none
module iptr_sva (
   input wire logic       CORE_CLK_IN,
   input wire logic       RESETN_IN,
   input wire logic       IRQ_REQ_OUT,
   input wire logic [5:0] IRQ_VECTOR_OUT,
   input wire logic [3:0] IRQ_LEVEL_OUT,
   input wire logic       IRQ_ACK_IN,
   input wire logic       INSTR_DONE_IN,
   input wire logic [3:0] CPU_LEVEL_OUT,
   input wire logic       DIV_ZERO_IN,
   input wire logic       DIV_ABORT_OUT,
   input wire logic       WDT_TIMEOUT_IN,
   input wire logic       UNINIT_W_IN,
   input wire logic       ILLEGAL_OP_IN,
   input wire logic       OP_FLUSHED_IN,
   input wire logic       BROWNOUT_IN,
   input wire logic       TRAP_LOCKOUT_IN,
   input wire logic       SOFT_RESET_IN,
   input wire logic       SYS_RESET_OUT,
   input wire logic       FETCH_RESTART_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   wire logic any_cause;
   assign any_cause = WDT_TIMEOUT_IN | UNINIT_W_IN | BROWNOUT_IN |
      (ILLEGAL_OP_IN & !OP_FLUSHED_IN) | TRAP_LOCKOUT_IN | SOFT_RESET_IN;
   sequence s_taken;
      IRQ_REQ_OUT && IRQ_ACK_IN;
   endsequence
   sequence s_new_req;
      $rose(IRQ_REQ_OUT);
   endsequence
   a_req_held: assert property (IRQ_REQ_OUT && !IRQ_ACK_IN |=>
      IRQ_REQ_OUT && $stable(IRQ_VECTOR_OUT) && $stable(IRQ_LEVEL_OUT))
      else $error("request changed before ack");
   a_ack_ends: assert property (s_taken |=> !IRQ_REQ_OUT)
      else $error("request stayed after ack");
   a_irq_above: assert property (s_new_req ##0 !IRQ_LEVEL_OUT[3] |->
      IRQ_LEVEL_OUT > $past(CPU_LEVEL_OUT) && IRQ_LEVEL_OUT != 4'h0)
      else $error("interrupt level not above cpu level");
   a_irq_vector: assert property (IRQ_REQ_OUT && !IRQ_LEVEL_OUT[3] |->
      IRQ_VECTOR_OUT >= 6'h08 && IRQ_VECTOR_OUT <= 6'h32 &&
      !(IRQ_VECTOR_OUT inside {6'h2F, 6'h30}))
      else $error("interrupt vector out of range");
   a_trap_vector: assert property (IRQ_REQ_OUT && IRQ_LEVEL_OUT[3] |->
      IRQ_VECTOR_OUT == {2'b00, IRQ_LEVEL_OUT - 4'h8})
      else $error("trap vector does not match level");
   a_trap_on_done: assert property (s_new_req ##0 IRQ_LEVEL_OUT[3] |->
      $past(INSTR_DONE_IN))
      else $error("trap launched mid instruction");
   a_trap_bit: assert property (s_taken ##0 IRQ_LEVEL_OUT[3] |=>
      CPU_LEVEL_OUT[3])
      else $error("trap level bit not set");
   a_irq_level: assert property (s_taken ##0 !IRQ_LEVEL_OUT[3] |=>
      CPU_LEVEL_OUT == $past(IRQ_LEVEL_OUT))
      else $error("cpu level not raised to accepted level");
   a_div_abort: assert property (1'b1 |=>
      DIV_ABORT_OUT == $past(DIV_ZERO_IN))
      else $error("divide abort pulse wrong");
   a_reset_cause: assert property (any_cause |=> SYS_RESET_OUT)
      else $error("reset cause without reset");
   a_fetch_restart: assert property (SYS_RESET_OUT |=> FETCH_RESTART_OUT)
      else $error("no fetch restart after reset");
endmodule : iptr_sva
bind iptr_resolver iptr_sva u_sva (
   .CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN),
   .IRQ_REQ_OUT(IRQ_REQ_OUT), .IRQ_VECTOR_OUT(IRQ_VECTOR_OUT),
   .IRQ_LEVEL_OUT(IRQ_LEVEL_OUT), .IRQ_ACK_IN(IRQ_ACK_IN),
   .INSTR_DONE_IN(INSTR_DONE_IN), .CPU_LEVEL_OUT(CPU_LEVEL_OUT),
   .DIV_ZERO_IN(DIV_ZERO_IN), .DIV_ABORT_OUT(DIV_ABORT_OUT),
   .WDT_TIMEOUT_IN(WDT_TIMEOUT_IN), .UNINIT_W_IN(UNINIT_W_IN),
   .ILLEGAL_OP_IN(ILLEGAL_OP_IN), .OP_FLUSHED_IN(OP_FLUSHED_IN),
   .BROWNOUT_IN(BROWNOUT_IN), .TRAP_LOCKOUT_IN(TRAP_LOCKOUT_IN),
   .SOFT_RESET_IN(SOFT_RESET_IN), .SYS_RESET_OUT(SYS_RESET_OUT),
   .FETCH_RESTART_OUT(FETCH_RESTART_OUT));
`default_nettype wire

// *** testbench/iptr_core_model.sv ***
// Processor core stand-in that accepts requests after a set delay
`timescale 1ns/1ns
`default_nettype none
module iptr_core_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       req_in,
   input  wire logic [5:0] vec_in,
   input  wire logic [3:0] lvl_in,
   input  wire logic [7:0] dly_in,
   output logic            ack_out,
   output logic      [9:0] got_out,
   output logic      [7:0] cnt_out
);
   logic [7:0] wait_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_out <= 1'b0;
         wait_q  <= 8'h00;
         got_out <= 10'h000;
         cnt_out <= 8'h00;
      end else begin
         ack_out <= 1'b0;
         if (req_in && !ack_out) begin
            if (wait_q >= dly_in) begin
               ack_out <= 1'b1;
               wait_q  <= 8'h00;
               got_out <= {vec_in, lvl_in};
               cnt_out <= cnt_out + 8'h01;
            end else begin
               wait_q <= wait_q + 8'h01;
            end
         end
      end
   end
endmodule : iptr_core_model
`default_nettype wire

// *** testbench/irq_priority_trap_resolver_tb.sv ***
// Register and request tests for the resolver
`timescale 1ns/1ns
`default_nettype none
module irq_priority_trap_resolver_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0000_0000;
   logic [53:0] ev = '0;
   logic [11:0] tr = 12'h000;
   logic [5:0]  rc = 6'h00;
   logic        flu = 1'b0;
   logic        done = 1'b1;
   logic        tret = 1'b0;
   logic        gs = 1'b0;
   logic [7:0]  dly = 8'h00;
   logic [23:0] fa = 24'h00_0010;
   logic [31:0] prd, rd;
   logic        prdy, perr, se, req, ack, dab, sysr, frs;
   logic [5:0]  vec;
   logic [3:0]  lvl, cpul;
   logic [23:0] rpc;
   logic [9:0]  got_v;
   logic [7:0]  nacc, n0;
   logic [3:0]  lt [11] = '{4'hB, 4'hB, 4'hB, 4'hB, 4'hC, 4'hC, 4'hC,
                            4'hC, 4'hC, 4'hC, 4'hD};
   int          errors = 0;
   int          n_checks = 0;
   always #5 clk = ~clk;
   iptr_resolver dut (
      .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
      .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
      .SRC_EVENT_IN(ev), .IRQ_REQ_OUT(req), .IRQ_VECTOR_OUT(vec),
      .IRQ_LEVEL_OUT(lvl), .IRQ_ACK_IN(ack), .INSTR_DONE_IN(done),
      .TRAP_RETURN_IN(tret), .CPU_LEVEL_OUT(cpul), .DIV_ZERO_IN(tr[0]),
      .ACC_OVF31_IN({2{tr[2]}}), .GUARD_USED_IN(gs),
      .ACC_OVF39_IN({2{tr[3]}}), .SAT_ANY_IN(gs), .SHIFT_BIG_IN(tr[1]),
      .DIV_ABORT_OUT(dab), .MISALIGN_IN(tr[4]), .DATA_UNIMPL_IN(tr[5]),
      .PROG_UNIMPL_IN(tr[6]), .FETCH_VALID_IN(tr[9]), .FETCH_ADDR_IN(fa),
      .MAC_SPLIT_IN(tr[7]), .X_IN_YSPACE_IN(tr[7]),
      .Y_IN_XSPACE_IN(tr[7]), .TRAP_VEC_BAD_IN(tr[8]),
      .STACK_ERR_IN(tr[10]), .OSC_FAIL_IN(tr[11]),
      .WDT_TIMEOUT_IN(rc[0]), .UNINIT_W_IN(rc[1]), .ILLEGAL_OP_IN(rc[2]),
      .OP_FLUSHED_IN(flu), .BROWNOUT_IN(rc[3]), .TRAP_LOCKOUT_IN(rc[4]),
      .SOFT_RESET_IN(rc[5]), .SYS_RESET_OUT(sysr),
      .FETCH_RESTART_OUT(frs), .RESET_PC_OUT(rpc));
   iptr_core_model core (
      .clk_in(clk), .rst_n_in(rst_n), .req_in(req), .vec_in(vec),
      .lvl_in(lvl), .dly_in(dly), .ack_out(ack), .got_out(got_v),
      .cnt_out(nacc));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (prdy !== 1'b1 && i < 50);
      if (i == 50) errors++;
      rd = prd;
      se = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rdc
   task automatic got(input logic [5:0] v, input logic [3:0] l);
      int i;
      logic [7:0] c;
      c = nacc;
      i = 0;
      while (nacc === c && i < 100) begin
         @(negedge clk);
         i++;
      end
      if (i == 100) errors++;
      chk(got_v, {v, l});
   endtask : got
   task automatic trap(input int i);
      @(posedge clk) tr[i] <= 1'b1;
      @(posedge clk) tr <= 12'h000;
   endtask : trap
   task automatic ret;
      @(posedge clk) tret <= 1'b1;
      @(posedge clk) tret <= 1'b0;
   endtask : ret
   task automatic pulse(input logic [53:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= '0;
   endtask : pulse
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   initial begin
      #100000;
      errors++;
      summarize;
   end
   initial begin
      repeat (2) @(posedge clk);
      chk(frs, 1'b1);
      chk(rpc, 24'h00_0000);
      rst_n <= 1'b1;
      rdc(12'h000, 32'h0000_4444);
      apb(1'b0, 12'h038, 32'h0000_0000);
      chk(se, 1'b1);
      apb(1'b1, 12'h000, 32'hFFFF_FFFF);
      rdc(12'h000, 32'h0000_7777);
      $display("test registers done");
      apb(1'b1, 12'h000, 32'h0000_3330);
      apb(1'b1, 12'h050, 32'h0000_0006);
      pulse(54'h6);
      got(6'h09, 4'h3);
      apb(1'b1, 12'h040, 32'h0000_FFFD);
      apb(1'b1, 12'h060, 32'h0000_0000);
      got(6'h0A, 4'h3);
      apb(1'b1, 12'h040, 32'h0000_0000);
      apb(1'b1, 12'h060, 32'h0000_0000);
      $display("test ties done");
      apb(1'b1, 12'h000, 32'h0000_0001);
      apb(1'b1, 12'h028, 32'h0000_0700);
      apb(1'b1, 12'h058, 32'h0000_0400);
      pulse(54'h400_0000_0001);
      got(6'h32, 4'h7);
      trap(0);
      got(6'h03, 4'hB);
      @(negedge clk) chk(cpul, 4'hF);
      trap(10);
      got(6'h05, 4'hD);
      ret;
      rdc(12'h060, 32'h0000_0007);
      apb(1'b1, 12'h040, 32'h0000_0000);
      apb(1'b1, 12'h048, 32'h0000_0000);
      pulse(54'h3F_FB80_0000_0000);
      rdc(12'h048, 32'h0000_0200);
      rdc(12'h04C, 32'h0000_0000);
      apb(1'b1, 12'h048, 32'h0000_0000);
      apb(1'b1, 12'h060, 32'h0000_0000);
      $display("test levels done");
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b1, 12'h050, 32'h0000_0020);
      n0 = nacc;
      pulse(54'h20);
      repeat (10) @(posedge clk);
      chk(nacc, n0);
      apb(1'b1, 12'h004, 32'h0000_0020);
      got(6'h0D, 4'h2);
      apb(1'b1, 12'h040, 32'h0000_0000);
      apb(1'b1, 12'h060, 32'h0000_0000);
      $display("test zero priority done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) rc[i] <= 1'b1;
         @(posedge clk) rc <= 6'h00;
         rdc(12'h068, 32'h0000_0001 << i);
         apb(1'b1, 12'h068, 32'h0000_0000);
      end
      @(posedge clk);
      rc[2] <= 1'b1;
      flu   <= 1'b1;
      @(posedge clk);
      rc  <= 6'h00;
      flu <= 1'b0;
      rdc(12'h068, 32'h0000_0000);
      $display("test reset causes done");
      n0 = nacc;
      trap(2);
      trap(3);
      repeat (3) @(posedge clk);
      chk(nacc, n0);
      apb(1'b1, 12'h064, 32'h0000_0007);
      @(posedge clk) done <= 1'b0;
      n0 = nacc;
      trap(1);
      repeat (5) @(posedge clk);
      chk(nacc, n0);
      @(posedge clk) done <= 1'b1;
      got(6'h03, 4'hB);
      ret;
      for (int i = 0; i < 11; i++) begin
         trap(i);
         got({2'b00, lt[i] - 4'h8}, lt[i]);
         ret;
      end
      $display("test traps done");
      @(posedge clk) dly <= 8'h14;
      trap(11);
      repeat (3) @(posedge clk);
      trap(4);
      rdc(12'h068, 32'h0000_0080);
      got(6'h06, 4'hE);
      $display("test conflict done");
      summarize;
   end
endmodule : irq_priority_trap_resolver_tb
`default_nettype wire
